// file: src/nsol_pkg.sv
// Overview of operation
// - each reset copies stored protection and option bytes into working registers
// - each reset loads factory trim into oscillator trim and fine trim bit
// - eight-byte unlock key held in eight consecutive nonvolatile bytes
// - key may disengage security only while backdoor unlock enable is 1
// - key accepted only from code running in secure memory, never debug
// - unlock enable 0 disables key; only mass erase plus blank check unlocks
// - lock state pattern 1:0 decodes as unsecured
// - factory defaults: unlock enable 1, redirect disable 1, lock state 1:0
// - rarely used registers sit in high page starting at 0x1800
// - RAM below 0x0100 is direct page reachable
// - RAM kept through wait and stop modes, undefined at power-on
// - RAM contents unchanged by any reset
// - reset stack pointer value is 0x00FF
// - secured: RAM blocked for debug port and non-secure code
// - command 0x41 mass erases only when no protection is enabled
// - command 0x05 sets array blank flag only if every byte erased
package nsol_pkg;
   localparam logic [15:0] NSOL_HIGH_PAGE = 16'h1800;
   localparam logic [15:0] NSOL_DIRECT_TOP = 16'h0100;
   localparam logic [15:0] NSOL_RESET_SP = 16'h00FF;
   localparam logic [15:0] NSOL_ADR_FLASH_CLOCK_DIVIDER = 16'h1820;
   localparam logic [15:0] NSOL_ADR_OPT = 16'h1821;
   localparam logic [15:0] NSOL_ADR_CFG = 16'h1823;
   localparam logic [15:0] NSOL_ADR_PROT = 16'h1824;
   localparam logic [15:0] NSOL_ADR_STAT = 16'h1825;
   localparam logic [15:0] NSOL_ADR_ORDER = 16'h1826;
   localparam logic [15:0] NSOL_ADR_KEYIN = 16'h1830;
   localparam logic [15:0] NSOL_ADR_KEYGO = 16'h1834;
   localparam logic [15:0] NSOL_ADR_TRIM = 16'h1838;
   localparam logic [15:0] NSOL_ADR_SC = 16'h1839;
   localparam logic [15:0] NSOL_ADR_SECST = 16'h183C;
   localparam logic [15:0] NSOL_NV_FINE_TRIM_BIT = 16'hFFAE;
   localparam logic [15:0] NSOL_NV_TRIM = 16'hFFAF;
   localparam logic [15:0] NSOL_NV_KEY = 16'hFFB0;
   localparam logic [15:0] NSOL_NV_PROT = 16'hFFBD;
   localparam logic [15:0] NSOL_NV_OPT = 16'hFFBF;
   localparam logic [7:0] NSOL_CMD_BLANK = 8'h05;
   localparam logic [7:0] NSOL_CMD_MASS = 8'h41;
   localparam int NSOL_OPT_BACKDOOR_UNLOCK_ENABLE = 7;
   localparam int NSOL_OPT_REDIR = 6;
   localparam int NSOL_STAT_CBEF = 7;
   localparam int NSOL_STAT_CCF = 6;
   localparam int NSOL_STAT_PVIOL = 5;
   localparam int NSOL_STAT_ACCERR = 4;
   localparam int NSOL_STAT_BLANK = 2;
   localparam int NSOL_CFG_KEYACC = 5;
   localparam logic [1:0] NSOL_SEC_OPEN = 2'b10;
   localparam logic [1:0] NSOL_SEC_ERASED = 2'b11;
   localparam logic [7:0] NSOL_OPT_FACTORY = 8'hC2;
   localparam logic [7:0] NSOL_PROT_FACTORY = 8'hFF;
   localparam logic [7:0] NSOL_ERASED = 8'hFF;
   localparam logic [7:0] NSOL_STAT_RST = 8'hC0;
   localparam logic [7:0] NSOL_TRIM_RST = 8'h80;
   localparam logic [4:0] NSOL_LOAD_STEPS = 5'd12;

   typedef enum logic [2:0] {
      NSOL_LOAD = 3'b000,
      NSOL_IDLE = 3'b001,
      NSOL_VERIFY = 3'b010,
      NSOL_ERASE = 3'b011
   } nsol_mode_t;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } nsol_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic wait_req;
   } nsol_rsp_t;
endpackage

// file: src/nsol_ram_guard.sv
`timescale 1ns/1ps
module nsol_ram_guard
   import nsol_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic secure_i,
   input wire logic dbg_req_i,
   input wire logic code_secure_i,
   input wire logic [15:0] ram_addr_i,
   input wire logic ram_req_i,
   output logic ram_grant_o,
   output logic direct_page_o
);
   typedef struct packed {
      logic grant;
      logic direct;
   } nsol_guard_t;
   nsol_guard_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      // RAM array is never cleared here, so reset keeps its content
      st_nxt.grant = ram_req_i & ~(secure_i & (dbg_req_i | ~code_secure_i));
      st_nxt.direct = ram_addr_i < NSOL_DIRECT_TOP;
      if (sys_rst_i) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   assign ram_grant_o = st_r.grant;
   assign direct_page_o = st_r.direct;

   secure_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (secure_i && dbg_req_i) |=> !ram_grant_o)
      else $error("ram granted to debug while secured");
endmodule

// file: src/nsol_top.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module nsol_top
   import nsol_pkg::*;
#(
   parameter int VERIFY_CYCLES = 32,
   parameter int ERASE_CYCLES = 64
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [7:0] avs_writedata_i,
   output logic [7:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [15:0] nv_addr_o,
   input wire logic [7:0] nv_data_i,
   input wire logic array_blank_i,
   input wire logic code_secure_i,
   input wire logic dbg_req_i,
   input wire logic [15:0] ram_addr_i,
   input wire logic ram_req_i,
   output logic ram_grant_o,
   output logic direct_page_o,
   output logic secure_o,
   output logic [7:0] osc_trim_reg_o,
   output logic fine_trim_bit_o,
   output logic [15:0] reset_sp_o,
   output logic erase_go_o
);
   typedef struct packed {
      nsol_mode_t mode;
      logic [4:0] step;
      logic [15:0] cnt;
      logic [7:0] prot;
      logic [7:0] opt;
      logic [63:0] key;
      logic [63:0] keyin;
      logic [7:0] div;
      logic div_done;
      logic keyacc;
      logic [7:0] stat;
      logic [7:0] order;
      logic [7:0] trim;
      logic fine_trim_bit;
      logic unlocked;
      logic erased;
      logic [7:0] rdata;
      logic ack;
      logic [15:0] nvaddr;
      logic erase_go;
      logic secure;
      logic wreq;
      logic [15:0] sp;
   } nsol_state_t;
   nsol_state_t st_r, st_nxt;
   logic secure_w;
   logic prot_on_w;
   logic hit_w;
   logic [7:0] rd_w;
   logic [15:0] step_addr_w;
   logic [4:0] fetch_w;

   // lock state anything but 1:0 stays secured unless unlocked
   assign secure_w = (st_r.opt[1:0] != NSOL_SEC_OPEN) && !st_r.unlocked;
   assign prot_on_w = !st_r.prot[0];
   assign hit_w = (avs_read_i | avs_write_i) & !st_r.ack & (st_r.mode != NSOL_LOAD);

   // address register plus flash latency: fetch runs two steps ahead of the byte taken
   assign fetch_w = st_r.step + ((st_r.step != 5'd0 || st_r.cnt[0]) ? 5'd2 : 5'd1);

   // load sequence: fine trim, trim, eight key bytes, protection, option
   always_comb begin
      step_addr_w = NSOL_NV_FINE_TRIM_BIT;
      if (fetch_w == 5'd1) begin
         step_addr_w = NSOL_NV_TRIM;
      end else if (fetch_w >= 5'd2 && fetch_w <= 5'd9) begin
         step_addr_w = NSOL_NV_KEY + 16'(fetch_w - 5'd2);
      end else if (fetch_w == 5'd10) begin
         step_addr_w = NSOL_NV_PROT;
      end else if (fetch_w == 5'd11) begin
         step_addr_w = NSOL_NV_OPT;
      end
   end

   // high page decode, unmapped reads zero
   always_comb begin
      rd_w = 8'h00;
      if (avs_address_i == NSOL_ADR_FLASH_CLOCK_DIVIDER) begin
         rd_w = {st_r.div_done, st_r.div[6:0]};
      end else if (avs_address_i == NSOL_ADR_OPT) begin
         rd_w = {st_r.opt[7:6], 4'h0, st_r.opt[1:0]};
      end else if (avs_address_i == NSOL_ADR_CFG) begin
         rd_w = {2'b00, st_r.keyacc, 5'b00000};
      end else if (avs_address_i == NSOL_ADR_PROT) begin
         rd_w = st_r.prot;
      end else if (avs_address_i == NSOL_ADR_STAT) begin
         rd_w = st_r.stat;
      end else if (avs_address_i == NSOL_ADR_ORDER) begin
         rd_w = st_r.order;
      end else if (avs_address_i == NSOL_ADR_TRIM) begin
         rd_w = st_r.trim;
      end else if (avs_address_i == NSOL_ADR_SC) begin
         rd_w = {7'h00, st_r.fine_trim_bit};
      end else if (avs_address_i == NSOL_ADR_SECST) begin
         rd_w = {6'h00, st_r.unlocked, secure_w};
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.erase_go = 1'b0;
      st_nxt.nvaddr = step_addr_w;
      st_nxt.secure = secure_w;
      case (st_r.mode)
         NSOL_LOAD: begin
            // nv_data_i answers the address presented in the previous cycle
            if (st_r.step != 5'd0 || st_r.cnt[0]) begin
               case (st_r.step)
                  5'd0: st_nxt.fine_trim_bit = nv_data_i[0];
                  5'd1: st_nxt.trim = nv_data_i;
                  5'd10: st_nxt.prot = nv_data_i;
                  5'd11: st_nxt.opt = nv_data_i;
                  default: st_nxt.key[8 * (9 - int'(st_r.step)) +: 8] = nv_data_i;
               endcase
               st_nxt.step = st_r.step + 5'd1;
               if (st_r.step == NSOL_LOAD_STEPS - 5'd1) begin
                  st_nxt.mode = NSOL_IDLE;
               end
            end else begin
               st_nxt.cnt = 16'd1;
            end
         end
         NSOL_VERIFY: begin
            st_nxt.cnt = st_r.cnt + 16'd1;
            if (st_r.cnt == 16'(VERIFY_CYCLES - 1)) begin
               st_nxt.mode = NSOL_IDLE;
               st_nxt.stat[NSOL_STAT_CCF] = 1'b1;
               st_nxt.stat[NSOL_STAT_CBEF] = 1'b1;
               if (array_blank_i) begin
                  st_nxt.stat[NSOL_STAT_BLANK] = 1'b1;
                  // erased array plus blank check lifts security
                  if (st_r.erased) begin
                     st_nxt.unlocked = 1'b1;
                  end
               end
            end
         end
         NSOL_ERASE: begin
            st_nxt.cnt = st_r.cnt + 16'd1;
            if (st_r.cnt == 16'(ERASE_CYCLES - 1)) begin
               st_nxt.mode = NSOL_IDLE;
               st_nxt.erased = 1'b1;
               st_nxt.stat[NSOL_STAT_CCF] = 1'b1;
               st_nxt.stat[NSOL_STAT_CBEF] = 1'b1;
            end
         end
         default: ;
      endcase
      if (hit_w) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = rd_w;
      end
      st_nxt.wreq = !st_nxt.ack;
      // writes land at the edge that sees waitrequest low
      if (st_r.ack && avs_write_i) begin
         if (avs_address_i == NSOL_ADR_FLASH_CLOCK_DIVIDER && !st_r.div_done && !st_r.stat[NSOL_STAT_ACCERR]) begin
            st_nxt.div = avs_writedata_i;
            st_nxt.div_done = 1'b1;
         end else if (avs_address_i == NSOL_ADR_CFG) begin
            st_nxt.keyacc = avs_writedata_i[NSOL_CFG_KEYACC];
         end else if (avs_address_i == NSOL_ADR_PROT) begin
            st_nxt.prot = avs_writedata_i;
         end else if (avs_address_i == NSOL_ADR_ORDER) begin
            st_nxt.order = avs_writedata_i;
         end else if (avs_address_i == NSOL_ADR_TRIM) begin
            st_nxt.trim = avs_writedata_i;
         end else if (avs_address_i == NSOL_ADR_SC) begin
            st_nxt.fine_trim_bit = avs_writedata_i[0];
         end else if (avs_address_i >= NSOL_ADR_KEYIN && avs_address_i < NSOL_ADR_KEYIN + 16'd4) begin
            st_nxt.keyin[8 * (7 - int'(avs_address_i[1:0])) +: 8] = avs_writedata_i;
         end else if (avs_address_i >= NSOL_ADR_KEYGO && avs_address_i < NSOL_ADR_KEYGO + 16'd4) begin
            st_nxt.keyin[8 * (3 - int'(avs_address_i[1:0])) +: 8] = avs_writedata_i;
            // last byte compares; only secure code, never debug, only with enable set
            if (avs_address_i[1:0] == 2'd3 && st_r.keyacc && st_r.opt[NSOL_OPT_BACKDOOR_UNLOCK_ENABLE]
                && code_secure_i && !dbg_req_i
                && {st_r.keyin[63:8], avs_writedata_i} == st_r.key) begin
               st_nxt.unlocked = 1'b1;
            end
         end else if (avs_address_i == NSOL_ADR_STAT) begin
            if (avs_writedata_i[NSOL_STAT_PVIOL]) begin
               st_nxt.stat[NSOL_STAT_PVIOL] = 1'b0;
            end
            if (avs_writedata_i[NSOL_STAT_ACCERR]) begin
               st_nxt.stat[NSOL_STAT_ACCERR] = 1'b0;
            end
            if (avs_writedata_i[NSOL_STAT_CBEF] && st_r.mode == NSOL_IDLE) begin
               st_nxt.cnt = 16'd0;
               st_nxt.stat[NSOL_STAT_CBEF] = 1'b0;
               st_nxt.stat[NSOL_STAT_CCF] = 1'b0;
               if (st_r.order == NSOL_CMD_BLANK) begin
                  st_nxt.stat[NSOL_STAT_BLANK] = 1'b0;
                  st_nxt.mode = NSOL_VERIFY;
               end else if (st_r.order == NSOL_CMD_MASS && !prot_on_w) begin
                  st_nxt.mode = NSOL_ERASE;
                  st_nxt.erase_go = 1'b1;
               end else if (st_r.order == NSOL_CMD_MASS) begin
                  st_nxt.stat[NSOL_STAT_PVIOL] = 1'b1;
                  st_nxt.stat[NSOL_STAT_CBEF] = 1'b1;
                  st_nxt.stat[NSOL_STAT_CCF] = 1'b1;
               end else begin
                  st_nxt.stat[NSOL_STAT_ACCERR] = 1'b1;
                  st_nxt.stat[NSOL_STAT_CBEF] = 1'b1;
                  st_nxt.stat[NSOL_STAT_CCF] = 1'b1;
               end
            end
         end
      end
      if (sys_rst_i) begin
         st_nxt = '0;
         st_nxt.mode = NSOL_LOAD;
         st_nxt.stat = NSOL_STAT_RST;
         st_nxt.trim = NSOL_TRIM_RST;
         st_nxt.prot = NSOL_PROT_FACTORY;
         st_nxt.opt = 8'h00;
         st_nxt.nvaddr = NSOL_NV_FINE_TRIM_BIT;
         st_nxt.secure = 1'b1;
         st_nxt.wreq = 1'b1;
         st_nxt.sp = NSOL_RESET_SP;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   nsol_ram_guard u_guard (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .secure_i(secure_w),
      .dbg_req_i(dbg_req_i),
      .code_secure_i(code_secure_i),
      .ram_addr_i(ram_addr_i),
      .ram_req_i(ram_req_i),
      .ram_grant_o(ram_grant_o),
      .direct_page_o(direct_page_o)
   );

   assign avs_readdata_o = st_r.rdata;
   assign avs_waitrequest_o = st_r.wreq;
   assign nv_addr_o = st_r.nvaddr;
   assign secure_o = st_r.secure;
   assign osc_trim_reg_o = st_r.trim;
   assign fine_trim_bit_o = st_r.fine_trim_bit;
   assign reset_sp_o = st_r.sp;
   assign erase_go_o = st_r.erase_go;

   sequence blank_run_s;
      st_r.mode == NSOL_IDLE && st_r.ack && avs_write_i && avs_address_i == NSOL_ADR_STAT
         && avs_writedata_i[NSOL_STAT_CBEF] && st_r.order == NSOL_CMD_BLANK;
   endsequence

   sequence erase_run_s;
      st_r.mode == NSOL_IDLE && st_r.ack && avs_write_i && avs_address_i == NSOL_ADR_STAT
         && avs_writedata_i[NSOL_STAT_CBEF] && st_r.order == NSOL_CMD_MASS;
   endsequence

   sequence verify_end_s;
      st_r.mode == NSOL_VERIFY ##1 st_r.mode == NSOL_IDLE;
   endsequence

   sequence dirty_end_s;
      st_r.mode == NSOL_VERIFY && !array_blank_i ##1 st_r.mode == NSOL_IDLE;
   endsequence

   sequence erase_end_s;
      st_r.mode == NSOL_ERASE ##1 st_r.mode == NSOL_IDLE;
   endsequence

   load_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd11) |=> st_r.opt == $past(nv_data_i))
      else $error("option byte not copied");
   trim_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd1) |=> osc_trim_reg_o == $past(nv_data_i))
      else $error("trim not loaded");
   key_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!st_r.opt[NSOL_OPT_BACKDOOR_UNLOCK_ENABLE] && !st_r.erased && !st_r.unlocked) |=> !st_r.unlocked)
      else $error("unlock without enable");
   dbg_key_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (dbg_req_i && !st_r.unlocked && st_r.mode != NSOL_VERIFY) |=> !st_r.unlocked)
      else $error("debug unlocked the part");
   open_decode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.opt[1:0] == NSOL_SEC_OPEN) |=> !secure_o)
      else $error("pattern 1:0 not open");
   secure_def_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.opt[1:0] != NSOL_SEC_OPEN && !st_r.unlocked) |=> secure_o)
      else $error("locked pattern not secure");
   mass_guard_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (erase_run_s and (prot_on_w)) |=> st_r.mode == NSOL_IDLE && st_r.stat[NSOL_STAT_PVIOL])
      else $error("erase ran under protection");
   blank_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      blank_run_s |=> st_r.mode == NSOL_VERIFY && !st_r.stat[NSOL_STAT_BLANK])
      else $error("verify did not start");
   stack_reset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      reset_sp_o == 16'h00FF)
      else $error("stack reset value wrong");
   bus_answer_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ((avs_read_i || avs_write_i) && st_r.mode != NSOL_LOAD && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("bus not answered");
   load_addr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd1) |-> $past(nv_addr_o) == NSOL_NV_TRIM)
      else $error("trim fetched from wrong cell");
   fine_trim_bit_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd0 && st_r.cnt[0])
         |=> {7'h00, fine_trim_bit_o} == ($past(nv_data_i) & 8'h01))
      else $error("fine trim not loaded");
   opt_addr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd11) |-> $past(nv_addr_o) == NSOL_NV_OPT)
      else $error("option fetched from wrong cell");
   prot_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd10) |=> st_r.prot == $past(nv_data_i))
      else $error("protection byte not copied");
   load_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r.mode == NSOL_LOAD && st_r.step == 5'd11) |=> st_r.mode == NSOL_IDLE)
      else $error("load did not finish");
   load_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      st_r.mode == NSOL_LOAD |-> avs_waitrequest_o)
      else $error("bus answered during load");
   answer_one_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer held too long");
   unlock_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      st_r.unlocked |=> st_r.unlocked)
      else $error("unlock lost before reset");
   unlock_open_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      st_r.unlocked |=> !secure_o)
      else $error("unlocked part still secure");
   erase_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      erase_go_o |-> st_r.mode == NSOL_ERASE && !prot_on_w)
      else $error("erase started under protection");
   erase_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      erase_go_o |=> !erase_go_o)
      else $error("erase start not a pulse");
   verify_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      verify_end_s |-> st_r.stat[NSOL_STAT_CCF] && st_r.stat[NSOL_STAT_CBEF])
      else $error("verify end flags missing");
   blank_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      dirty_end_s |-> !st_r.stat[NSOL_STAT_BLANK])
      else $error("blank flag on dirty array");
   erase_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      erase_end_s |-> st_r.erased && st_r.stat[NSOL_STAT_CCF])
      else $error("erase end not recorded");
   key_secure_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!code_secure_i && !st_r.unlocked && st_r.mode != NSOL_VERIFY) |=> !st_r.unlocked)
      else $error("non-secure code unlocked");
endmodule

// file: tb/nsol_flash_model.sv
`timescale 1ns/1ps
module nsol_flash_model
   import nsol_pkg::*;
(
   input wire logic clk_i,
   input wire logic [15:0] nv_addr_i,
   input wire logic [7:0] stored_opt_i,
   input wire logic [7:0] stored_prot_i,
   output logic [7:0] nv_data_o = 8'h00
);
   // one-cycle read latency; unmapped cells toggle so stale data never looks valid
   always @(posedge clk_i) begin
      if (nv_addr_i == NSOL_NV_FINE_TRIM_BIT) nv_data_o <= 8'h01;
      else if (nv_addr_i == NSOL_NV_TRIM) nv_data_o <= 8'h5A;
      else if (nv_addr_i[15:3] == NSOL_NV_KEY[15:3]) nv_data_o <= 8'h11 * ({5'h00, nv_addr_i[2:0]} + 8'h01);
      else if (nv_addr_i == NSOL_NV_PROT) nv_data_o <= stored_prot_i;
      else if (nv_addr_i == NSOL_NV_OPT) nv_data_o <= stored_opt_i;
      else nv_data_o <= ~nv_data_o;
   end
endmodule

// file: tb/nsol_top_tb.sv
`timescale 1ns/1ps
module nsol_top_tb;
   import nsol_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [15:0] avs_address_i = 16'h0000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [7:0] avs_writedata_i = 8'h00;
   logic [7:0] avs_readdata_o, nv_data, osc_trim_reg_o;
   logic avs_waitrequest_o, ram_grant_o, direct_page_o, secure_o, fine_trim_bit_o, erase_go_o;
   logic [15:0] nv_addr_o, reset_sp_o;
   logic array_blank_i = 1'b0;
   logic code_secure_i = 1'b0;
   logic dbg_req_i = 1'b0;
   logic [15:0] ram_addr_i = 16'h0000;
   logic ram_req_i = 1'b0;
   logic [7:0] opt_byte = 8'hC3;
   logic [7:0] prot_byte = 8'hFE;
   logic [7:0] rd;
   int n_errors = 0;
   int samples_checked = 0;
   int n_go = 0;
   nsol_top #(.VERIFY_CYCLES(8), .ERASE_CYCLES(8)) nsol_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .nv_addr_o(nv_addr_o), .nv_data_i(nv_data), .array_blank_i(array_blank_i), .code_secure_i(code_secure_i),
      .dbg_req_i(dbg_req_i), .ram_addr_i(ram_addr_i), .ram_req_i(ram_req_i), .ram_grant_o(ram_grant_o),
      .direct_page_o(direct_page_o), .secure_o(secure_o), .osc_trim_reg_o(osc_trim_reg_o),
      .fine_trim_bit_o(fine_trim_bit_o), .reset_sp_o(reset_sp_o), .erase_go_o(erase_go_o));
   nsol_flash_model nsol_flash_model_inst (.clk_i(clk_i), .nv_addr_i(nv_addr_o), .stored_opt_i(opt_byte),
      .stored_prot_i(prot_byte), .nv_data_o(nv_data));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      if (erase_go_o === 1'b1) n_go <= n_go + 1;
   end
   task automatic complete_run();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
      int n;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      for (n = 0; n < 200; n++) begin
         @(negedge clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      rd = avs_readdata_o;
      @(posedge clk_i);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
      if (n == 200) begin
         n_errors++;
         complete_run();
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk_val({8'h00, rd}, {8'h00, exp});
   endtask
   task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
      opt_byte <= opt;
      prot_byte <= prot;
      sys_rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      bus(1'b0, NSOL_ADR_SECST, 8'h00);
   endtask
   task automatic sec_chk(input logic exp);
      repeat (20) @(posedge clk_i);
      chk_bit(secure_o, exp);
   endtask
   task automatic send_key(input logic [7:0] flip, input logic dbg, input logic cs);
      dbg_req_i <= dbg;
      code_secure_i <= cs;
      for (int i = 0; i < 8; i++) bus(1'b1, NSOL_ADR_KEYIN + 16'(i), (8'h11 * 8'(i + 1)) ^ flip);
      dbg_req_i <= 1'b0;
      code_secure_i <= 1'b0;
   endtask
   task automatic launch(input logic [7:0] code);
      int n;
      bus(1'b1, NSOL_ADR_ORDER, code);
      bus(1'b1, NSOL_ADR_STAT, 8'h80);
      for (n = 0; n < 60; n++) begin
         bus(1'b0, NSOL_ADR_STAT, 8'h00);
         if (rd[NSOL_STAT_CCF] === 1'b1 || rd[NSOL_STAT_PVIOL] === 1'b1) break;
      end
      if (n == 60) begin
         n_errors++;
         complete_run();
      end
   endtask
   task automatic ram_chk(input logic dbg, input logic cs, input logic [15:0] a, input logic g, input logic dp);
      dbg_req_i <= dbg;
      code_secure_i <= cs;
      ram_addr_i <= a;
      ram_req_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_bit(ram_grant_o, g);
      chk_bit(direct_page_o, dp);
      ram_req_i <= 1'b0;
      dbg_req_i <= 1'b0;
      code_secure_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic t_load();
      do_reset(8'hC3, 8'hFE);
      rd_chk(NSOL_ADR_OPT, 8'hC3);
      rd_chk(NSOL_ADR_PROT, 8'hFE);
      rd_chk(NSOL_ADR_TRIM, 8'h5A);
      chk_val({8'h00, osc_trim_reg_o}, 16'h005A);
      chk_bit(fine_trim_bit_o, 1'b1);
      chk_val(reset_sp_o, NSOL_RESET_SP);
      chk_bit(secure_o, 1'b1);
      rd_chk(16'h1822, 8'h00);
      bus(1'b1, NSOL_ADR_TRIM, 8'h33);
      chk_val({8'h00, osc_trim_reg_o}, 16'h0033);
   endtask
   task automatic t_ram_key();
      ram_chk(1'b1, 1'b1, 16'h00FF, 1'b0, 1'b1);
      ram_chk(1'b0, 1'b0, 16'h0100, 1'b0, 1'b0);
      ram_chk(1'b0, 1'b1, 16'h0040, 1'b1, 1'b1);
      bus(1'b1, NSOL_ADR_CFG, 8'h20);
      send_key(8'h01, 1'b0, 1'b1);
      sec_chk(1'b1);
      send_key(8'h00, 1'b1, 1'b1);
      sec_chk(1'b1);
      send_key(8'h00, 1'b0, 1'b0);
      sec_chk(1'b1);
      send_key(8'h00, 1'b0, 1'b1);
      sec_chk(1'b0);
      rd_chk(NSOL_ADR_SECST, 8'h02);
      ram_chk(1'b1, 1'b0, 16'h0080, 1'b1, 1'b1);
   endtask
   task automatic t_erase();
      do_reset(8'h43, 8'hFE);
      bus(1'b1, NSOL_ADR_CFG, 8'h20);
      send_key(8'h00, 1'b0, 1'b1);
      sec_chk(1'b1);
      launch(NSOL_CMD_MASS);
      chk_bit(rd[NSOL_STAT_PVIOL], 1'b1);
      chk_val(16'(n_go), 16'h0000);
      do_reset(8'h43, 8'hFF);
      array_blank_i <= 1'b0;
      launch(NSOL_CMD_BLANK);
      chk_bit(rd[NSOL_STAT_BLANK], 1'b0);
      launch(NSOL_CMD_MASS);
      chk_val(16'(n_go), 16'h0001);
      array_blank_i <= 1'b1;
      launch(NSOL_CMD_BLANK);
      chk_bit(rd[NSOL_STAT_BLANK], 1'b1);
      sec_chk(1'b0);
      do_reset(8'h43, 8'hFF);
      chk_bit(secure_o, 1'b1);
      do_reset(NSOL_OPT_FACTORY, NSOL_PROT_FACTORY);
      chk_bit(secure_o, 1'b0);
   endtask
   initial begin
      t_load();
      t_ram_key();
      t_erase();
      complete_run();
   end
endmodule
